// File: common/ioecs_defs.svh
/*
 * Constants for the expander configuration sequencer: expander register
 * numbers, data values, expander indices and timing.
 * Assumes the includer has no other macros of these names.
 */
`ifndef IOECS_DEFS_SVH
`define IOECS_DEFS_SVH
`define IOECS_REG_IN_LO      8'h00
`define IOECS_REG_IN_HI      8'h01
`define IOECS_REG_OUT_LO     8'h02
`define IOECS_REG_OUT_HI     8'h03
`define IOECS_REG_INV_LO     8'h04
`define IOECS_REG_INV_HI     8'h05
`define IOECS_REG_DIR_LO     8'h06
`define IOECS_REG_DIR_HI     8'h07
`define IOECS_NO_INVERT      8'h00
`define IOECS_DIR_ALL_IN     8'hFF
`define IOECS_DIR_ALL_OUT    8'h00
`define IOECS_EXP_MRL        4'h8
`define IOECS_EXP_FRST       4'hB
`define IOECS_EXP_LINK       4'hC
`define IOECS_EXP_ACT        4'hD
`define IOECS_CLK_MHZ        125
`define IOECS_UPDATE_MS      40
`define IOECS_UPDATE_CYC     (`IOECS_UPDATE_MS * 1000 * `IOECS_CLK_MHZ)
`endif

// File: common/ioecs_pkg.sv
/*
 * Types for the expander configuration sequencer.
 * Assumes nothing of its surroundings.
 */
package ioecs_pkg;
    typedef enum logic [5:0] {
        IOECS_IDLE = 6'b00_0001,
        IOECS_ISSUE = 6'b00_0010,
        IOECS_WAIT = 6'b00_0100,
        IOECS_NEXT = 6'b00_1000,
        IOECS_HOLD = 6'b01_0000,
        IOECS_SYNC = 6'b10_0000
    } ioecs_state_type;
endpackage

// File: design/ioecs_period_timer.sv
/*
 * Update period timer: counts down one update period after each restart
 * and reports when the period has expired.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module ioecs_period_timer #(
    parameter int unsigned PERIOD_CYC = 5_000_000
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    output logic expired_o
);
    logic [31:0] cnt_q;

    initial begin
        if (PERIOD_CYC < 1) begin
            $error("ioecs_period_timer: PERIOD_CYC must be at least one");
        end
    end

    // Loads PERIOD_CYC - 1 on restart, counts to zero, expired at zero.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_q <= 32'h0000_0000;
        end else if (restart_i) begin
            cnt_q <= 32'(PERIOD_CYC - 1);
        end else if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end

    assign expired_o = (cnt_q == 32'h0000_0000) && !restart_i;
endmodule

// File: design/ioecs_sequencer.sv
/*
 * Expander configuration sequencer: configures the input-only expanders
 * and the status expanders, then resends the internal link view to them when it
 * differs from the values last written, at most once per update period.
 * Assumes an SMBus master that takes one command per start pulse and
 * answers with a one-cycle done pulse; all inputs are on core_clk_i.
 */
// How it works
// RQ1: Input-only expanders get direction registers 6 and 7 all inputs.
// RQ2: Then registers 0 and 1 are read to capture pin states.
// RQ3: Every sequence writes zero to inversion registers 4 and 5.
// RQ4: Status expanders get link-up state in output register 2.
// RQ5: Status expanders get link-activity state in output register 3.
// RQ6: Status expanders get direction registers 6 and 7 all outputs.
// RQ7: Status order is outputs 2,3, then inversion 4,5, then direction 6,7.
// RQ8: While enabled, any mismatch between internal and expander state is sent; a change between the link and activity expander writes is missed.
// RQ9: Hot reset defaults reaching the internal view are pushed out too.
// RQ10: The input-only sequence goes to expanders 8 and 11.
// RQ11: Outputs update no more than once per 40 ms period.
// RQ12: Each step is its own transaction; next waits for completion.
`timescale 1ns/1ps
`include "ioecs_defs.svh"
module ioecs_sequencer
    import ioecs_pkg::*;
#(
    parameter int unsigned UPDATE_CYC = `IOECS_UPDATE_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic start_cfg_i,
    input wire logic [6:0] addr_mrl_i,
    input wire logic [6:0] addr_frst_i,
    input wire logic [6:0] addr_link_i,
    input wire logic [6:0] addr_act_i,
    input wire logic [7:0] link_up_i,
    input wire logic [7:0] link_act_i,
    input wire logic smb_done_i,
    input wire logic smb_err_i,
    input wire logic [7:0] smb_rdata_i,
    output logic smb_start_o,
    output logic smb_read_o,
    output logic [6:0] smb_addr_o,
    output logic [7:0] smb_cmd_o,
    output logic [7:0] smb_wdata_o,
    output logic busy_o,
    output logic cfg_done_o,
    output logic [15:0] mrl_state_o,
    output logic [15:0] frst_state_o
);
    // Steps 0..5 for every expander: input-only and status sequences alike; resync reruns steps 0..5 on both status expanders.
    localparam logic [3:0] LAST_IN = 4'd7;
    localparam logic [3:0] LAST_ST = 4'd5;

    ioecs_state_type state_q;
    logic [1:0] exp_q;      // 0 mrl, 1 frst, 2 link, 3 activity
    logic [3:0] step_q;
    logic [7:0] up_sent_q;
    logic [7:0] act_sent_q;
    logic period_restart;
    logic period_ok;
    logic mismatch;
    logic [6:0] cur_addr;
    logic cur_read;
    logic [7:0] cur_cmd;
    logic [7:0] cur_data;

    ioecs_period_timer #(
        .PERIOD_CYC(UPDATE_CYC)
    ) u_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .restart_i(period_restart),
        .expired_o(period_ok)
    );

    // RQ8 state compare: hot reset defaults appear here as well (RQ9).
    assign mismatch = (link_up_i != up_sent_q) || (link_act_i != act_sent_q);

    // Address per expander; input-only targets are expanders 8 and 11.
    // RQ10 target expanders
    always_comb begin
        case (exp_q)
            2'd0: cur_addr = addr_mrl_i;
            2'd1: cur_addr = addr_frst_i;
            2'd2: cur_addr = addr_link_i;
            default: cur_addr = addr_act_i;
        endcase
    end

    // Step table for the input-only and the status sequences.
    // RQ7 status order
    always_comb begin
        cur_read = 1'b0;
        cur_cmd = `IOECS_REG_INV_LO;
        cur_data = `IOECS_NO_INVERT;
        if (!exp_q[1]) begin
            case (step_q)
                // RQ3 no inversion
                4'd0: cur_cmd = `IOECS_REG_INV_LO;
                4'd1: cur_cmd = `IOECS_REG_INV_HI;
                // RQ1 all inputs
                4'd2: begin
                    cur_cmd = `IOECS_REG_DIR_LO;
                    cur_data = `IOECS_DIR_ALL_IN;
                end
                4'd3: begin
                    cur_cmd = `IOECS_REG_DIR_HI;
                    cur_data = `IOECS_DIR_ALL_IN;
                end
                // RQ2 capture pins
                4'd4: begin
                    cur_cmd = `IOECS_REG_IN_LO;
                    cur_read = 1'b1;
                end
                default: begin
                    cur_cmd = `IOECS_REG_IN_HI;
                    cur_read = 1'b1;
                end
            endcase
        end else begin
            case (step_q)
                // RQ4 link-up data
                4'd0: begin
                    cur_cmd = `IOECS_REG_OUT_LO;
                    cur_data = link_up_i;
                end
                // RQ5 activity data
                4'd1: begin
                    cur_cmd = `IOECS_REG_OUT_HI;
                    cur_data = link_act_i;
                end
                4'd2: cur_cmd = `IOECS_REG_INV_LO;
                4'd3: cur_cmd = `IOECS_REG_INV_HI;
                // RQ6 all outputs
                4'd4: begin
                    cur_cmd = `IOECS_REG_DIR_LO;
                    cur_data = `IOECS_DIR_ALL_OUT;
                end
                default: begin
                    cur_cmd = `IOECS_REG_DIR_HI;
                    cur_data = `IOECS_DIR_ALL_OUT;
                end
            endcase
        end
    end

    // Restart the update period whenever a status expander write is launched.
    // RQ11 period restart
    assign period_restart = (state_q == IOECS_ISSUE) && exp_q[1] && !cur_read;

    // Main sequencing: one transaction per step, waiting for completion.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= IOECS_IDLE;
            exp_q <= 2'd0;
            step_q <= 4'd0;
        end else begin
            case (state_q)
                IOECS_IDLE: begin
                    if (enable_i && start_cfg_i) begin
                        exp_q <= 2'd0;
                        step_q <= 4'd0;
                        state_q <= IOECS_HOLD;
                    end
                end
                IOECS_HOLD: begin
                    // RQ11 wait period
                    if (!exp_q[1] || period_ok) begin
                        state_q <= IOECS_ISSUE;
                    end
                end
                IOECS_ISSUE: state_q <= IOECS_WAIT;
                // RQ12 wait completion
                IOECS_WAIT: begin
                    if (smb_done_i) begin
                        state_q <= IOECS_NEXT;
                    end
                end
                IOECS_NEXT: begin
                    if (step_q != (exp_q[1] ? LAST_ST : LAST_IN - 4'd2)) begin
                        step_q <= step_q + 4'd1;
                        state_q <= (exp_q[1] ? IOECS_HOLD : IOECS_ISSUE);
                    end else if (exp_q != 2'd3) begin
                        exp_q <= exp_q + 2'd1;
                        step_q <= 4'd0;
                        state_q <= IOECS_HOLD;
                    end else begin
                        state_q <= IOECS_SYNC;
                    end
                end
                IOECS_SYNC: begin
                    // RQ8 resolve conflict
                    if (!enable_i) begin
                        state_q <= IOECS_IDLE;
                    end else if (mismatch && period_ok) begin
                        exp_q <= 2'd2;
                        step_q <= 4'd0;
                        state_q <= IOECS_ISSUE;
                    end
                end
                default: state_q <= IOECS_IDLE;
            endcase
        end
    end

    // Records what the status expanders were last told.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            up_sent_q <= 8'h00;
            act_sent_q <= 8'h00;
        end else if (period_restart && step_q == 4'd0) begin
            up_sent_q <= cur_data;
        end else if (period_restart && step_q == 4'd1) begin
            act_sent_q <= cur_data;
        end
    end

    // Captures the read pin states of expanders 8 and 11.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mrl_state_o <= 16'h0000;
            frst_state_o <= 16'h0000;
        end else if (state_q == IOECS_WAIT && smb_done_i && smb_read_o
                     && !smb_err_i) begin
            if (exp_q == 2'd0 && step_q == 4'd4) begin
                mrl_state_o[7:0] <= smb_rdata_i;
            end else if (exp_q == 2'd0) begin
                mrl_state_o[15:8] <= smb_rdata_i;
            end else if (step_q == 4'd4) begin
                frst_state_o[7:0] <= smb_rdata_i;
            end else begin
                frst_state_o[15:8] <= smb_rdata_i;
            end
        end
    end

    // Registered command outputs to the SMBus master.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            smb_start_o <= 1'b0;
            smb_read_o <= 1'b0;
            smb_addr_o <= 7'h00;
            smb_cmd_o <= 8'h00;
            smb_wdata_o <= 8'h00;
            busy_o <= 1'b0;
            cfg_done_o <= 1'b0;
        end else begin
            smb_start_o <= (state_q == IOECS_ISSUE);
            if (state_q == IOECS_ISSUE) begin
                smb_read_o <= cur_read;
                smb_addr_o <= cur_addr;
                smb_cmd_o <= cur_cmd;
                smb_wdata_o <= cur_data;
            end
            busy_o <= (state_q != IOECS_IDLE) && (state_q != IOECS_SYNC);
            cfg_done_o <= (state_q == IOECS_SYNC);
        end
    end

    // Output updates are spaced by at least nine cycles.
    a_update_spacing: assert property (@(posedge core_clk_i) disable iff (rst_i)
        period_restart |=> !period_restart [*8]) // RQ11
        else $error("output writes too close together");

    // A new command never starts while one is outstanding.
    a_one_outstanding: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (state_q == IOECS_WAIT && !smb_done_i) |=> !smb_start_o) // RQ12
        else $error("command started before completion");

    // Expander 8 writes to direction register 6 select all inputs.
    a_dir_inputs: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (smb_start_o && smb_addr_o == addr_mrl_i && exp_q == 2'd0
         && smb_cmd_o == `IOECS_REG_DIR_LO) |-> smb_wdata_o == 8'hFF) // RQ1
        else $error("input-only direction not all inputs");

    // Inversion writes always carry zero.
    a_no_invert: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (smb_start_o && (smb_cmd_o == `IOECS_REG_INV_LO
         || smb_cmd_o == `IOECS_REG_INV_HI)) |-> smb_wdata_o == 8'h00) // RQ3
        else $error("inversion register written non-zero");

    // Status direction writes select all outputs.
    a_dir_outputs: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (smb_start_o && exp_q[1] && smb_cmd_o[7:1] == 7'h03)
        |-> smb_wdata_o == 8'h00) // RQ6
        else $error("status direction not all outputs");

    // Register 0 and 1 accesses are reads.
    a_pin_reads: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (smb_start_o && smb_cmd_o[7:1] == 7'h00) |-> smb_read_o) // RQ2
        else $error("pin state access was not a read");

    // Link-up data sent in output register 2.
    a_link_data: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (smb_start_o && exp_q[1] && smb_cmd_o == `IOECS_REG_OUT_LO)
        |-> smb_wdata_o == $past(link_up_i)) // RQ4
        else $error("link-up data wrong");

    // Activity data sent in output register 3.
    a_act_data: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (smb_start_o && exp_q[1] && smb_cmd_o == `IOECS_REG_OUT_HI)
        |-> smb_wdata_o == $past(link_act_i)) // RQ5
        else $error("activity data wrong");
endmodule

// File: dv/ioecs_exp_model.sv
/*
 * Behavioural model of the SMBus I/O expanders at the far side.
 * Assumes one command per start pulse, with address, register number,
 * direction and data held by the sequencer until the next start.
 */
`timescale 1ns/1ps
module ioecs_exp_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] lat_i,
    input wire logic smb_start_i,
    input wire logic smb_read_i,
    input wire logic [6:0] smb_addr_i,
    input wire logic [7:0] smb_cmd_i,
    output logic smb_done_o,
    output logic smb_err_o,
    output logic [7:0] smb_rdata_o
);
    logic pend_q;
    logic [3:0] cnt_q;
    // Answers each command lat_i + 1 cycles after its start; read data is junk otherwise.
    // Input pins of each expander show a pattern derived from its address.
    always_ff @(posedge core_clk_i) begin
        smb_done_o <= 1'b0;
        smb_err_o <= 1'b0;
        smb_rdata_o <= ~smb_rdata_o;
        if (rst_i) begin
            pend_q <= 1'b0;
            cnt_q <= 4'h0;
            smb_rdata_o <= 8'h5a;
        end else if (smb_start_i) begin
            pend_q <= 1'b1;
            cnt_q <= lat_i;
        end else if (pend_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            smb_done_o <= 1'b1;
            if (smb_read_i) begin
                smb_rdata_o <= smb_cmd_i[0] ? {1'b0, ~smb_addr_i}
                                            : {1'b1, smb_addr_i};
            end
        end
    end
endmodule

// File: dv/test_io_expander_config_sequencer.sv
/*
 * Self-checking bench for the expander configuration sequencer.
 * Assumes the expander model answers every command of the sequencer.
 */
`timescale 1ns/1ps
module test_io_expander_config_sequencer;
    localparam int UPD = 50;
    localparam logic [6:0] A_MRL = 7'h20;
    localparam logic [6:0] A_FRST = 7'h23;
    localparam logic [6:0] A_LINK = 7'h24;
    localparam logic [6:0] A_ACT = 7'h25;
    logic clk = 1'b0, rst = 1'b1, enable = 1'b0, start_cfg = 1'b0;
    logic [7:0] link_up = 8'ha5, link_act = 8'h3c;
    logic [3:0] lat = 4'h0;
    logic done, err, start, rd, busy, cfg_done, pend = 1'b0;
    logic [7:0] rdata, cmd, wdata;
    logic [6:0] addr;
    logic [15:0] mrl, frst;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    logic [23:0] log_q[$];
    int tim_q[$];

    ioecs_sequencer #(.UPDATE_CYC(UPD)) i_dut (.core_clk_i(clk),
        .rst_i(rst), .enable_i(enable), .start_cfg_i(start_cfg),
        .addr_mrl_i(A_MRL), .addr_frst_i(A_FRST), .addr_link_i(A_LINK),
        .addr_act_i(A_ACT), .link_up_i(link_up), .link_act_i(link_act),
        .smb_done_i(done), .smb_err_i(err), .smb_rdata_i(rdata),
        .smb_start_o(start), .smb_read_o(rd), .smb_addr_o(addr),
        .smb_cmd_o(cmd), .smb_wdata_o(wdata), .busy_o(busy),
        .cfg_done_o(cfg_done), .mrl_state_o(mrl), .frst_state_o(frst));
    ioecs_exp_model i_exp (.core_clk_i(clk), .rst_i(rst), .lat_i(lat),
        .smb_start_i(start), .smb_read_i(rd), .smb_addr_i(addr),
        .smb_cmd_i(cmd), .smb_done_o(done), .smb_err_o(err),
        .smb_rdata_o(rdata));

    // Clock at 125 MHz.
    always #4 clk = ~clk;

    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Logs every started command and its cycle; cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (done === 1'b1) pend = 1'b0;
        if (start === 1'b1) begin
            chk("start while pending", 24'h0, {23'h0, pend});
            pend = 1'b1;
            log_q.push_back({rd, addr, cmd, wdata});
            tim_q.push_back(cyc);
        end
        if (cyc > 9000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic wait_log(int n);
        int k;
        k = 0;
        while (log_q.size() < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        #1;
    endtask

    task automatic chk_status(int base, logic [7:0] up, logic [7:0] act);
        logic [7:0] d [6];
        d = '{up, act, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 6; s++) begin
                chk("status step", {1'b0, e ? A_ACT : A_LINK, 8'(s + 2),
                    d[s]}, log_q[base + e * 6 + s]);
            end
        end
    endtask

    task automatic t_enable();
        @(posedge clk);
        start_cfg <= 1'b1;
        @(posedge clk);
        start_cfg <= 1'b0;
        repeat (20) @(posedge clk);
        chk("commands while disabled", 24'h0, 24'(log_q.size()));
        $display("test enable done");
    endtask

    task automatic t_config();
        logic [23:0] g;
        logic [6:0] a;
        int s;
        enable <= 1'b1;
        start_cfg <= 1'b1;
        @(posedge clk);
        start_cfg <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("busy during config", 24'h1, {23'h0, busy});
        wait_log(24);
        for (int i = 0; i < 12; i++) begin
            a = i < 6 ? A_MRL : A_FRST;
            s = i % 6;
            g = log_q[i];
            if (s > 3) g[7:0] = 8'h00;
            chk("input step", {s > 3, a, 8'(s < 4 ? s + 4 : s - 4),
                s < 2 || s > 3 ? 8'h00 : 8'hff}, g);
        end
        chk_status(12, 8'ha5, 8'h3c);
        for (int k = 0; k < 400 && cfg_done !== 1'b1; k++) @(posedge clk);
        chk("cfg done", 24'h1, {23'h0, cfg_done});
        @(posedge clk);
        #1;
        chk("busy after config", 24'h0, {23'h0, busy});
        chk("mrl pins", {8'h0, 1'b0, ~A_MRL, 1'b1, A_MRL}, 24'(mrl));
        chk("frst pins", {8'h0, 1'b0, ~A_FRST, 1'b1, A_FRST}, 24'(frst));
        $display("test config done");
    endtask

    // A start request in the sync state must be ignored.
    task automatic t_conflict(logic [7:0] up, logic [7:0] act,
                              logic [3:0] lt);
        int n0;
        n0 = log_q.size();
        link_up <= up;
        link_act <= act;
        lat <= lt;
        start_cfg <= 1'b1;
        @(posedge clk);
        start_cfg <= 1'b0;
        wait_log(n0 + 12);
        chk_status(n0, up, act);
        $display("test conflict done");
    endtask

    task automatic t_quiet();
        int n0;
        int last;
        n0 = log_q.size();
        repeat (3 * UPD) @(posedge clk);
        chk("idle commands", 24'(n0), 24'(log_q.size()));
        last = -UPD;
        for (int i = 0; i < log_q.size(); i++) begin
            if (log_q[i][23] == 1'b0 && log_q[i][15:8] < 8'h04) begin
                chk("update gap", 24'h1, 24'(tim_q[i] - last >= UPD));
                last = tim_q[i];
            end
        end
        $display("test quiet done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_enable();
        t_config();
        t_conflict(8'h0f, 8'hf0, 4'h5);
        t_conflict(8'hff, 8'hff, 4'h2);
        t_quiet();
        final_report();
    end
endmodule
